// file: prtb_pkg.sv
// Package for the receive tuning register bank: offsets, layouts, resets, timing.
// Assumes a 100 MHz core clock and a classic Wishbone slave with 32-bit data.
package prtb_pkg;
    // Printed register indices; byte address is four times the index
    localparam logic [7:0]  IDX_FIFO_CTRL   = 8'h33;
    localparam logic [7:0]  IDX_FE_CFG      = 8'h43;
    localparam logic [7:0]  IDX_IDLE_CFG    = 8'h53;
    localparam logic [9:0]  ADDR_FIFO_CTRL  = {IDX_FIFO_CTRL, 2'b00};
    localparam logic [9:0]  ADDR_FE_CFG     = {IDX_FE_CFG, 2'b00};
    localparam logic [9:0]  ADDR_IDLE_CFG   = {IDX_IDLE_CFG, 2'b00};
    // Field positions
    localparam int POS_FIFO_SKIP   = 4;
    localparam int POS_TMR_OFF     = 11;
    localparam int POS_RECOV_LO    = 7;
    localparam int POS_FORCE_LINK  = 6;
    localparam int POS_TERNARY     = 5;
    localparam int POS_GAP         = 4;
    localparam int POS_DEC_SKIP    = 3;
    localparam int POS_SCR_OFF     = 2;
    localparam int POS_ODD_NIB     = 1;
    localparam int POS_EARLY_DV    = 0;
    // Reset values
    localparam logic [15:0] RST_FIFO_CTRL  = 16'h0000;
    localparam logic [15:0] RST_FE_CFG     = 16'h07A0;
    localparam logic [15:0] RST_IDLE_CFG   = 16'h2055;
    // Writable bit masks; everything else holds its fixed value
    localparam logic [15:0] WMASK_FIFO_CTRL = 16'h0010;
    localparam logic [15:0] WMASK_FE_CFG    = 16'h0FFF;
    localparam logic [15:0] WMASK_IDLE_CFG  = 16'h000F;
    // Timing
    localparam int CLK_FREQ_HZ      = 100_000_000;
    localparam int PKT_LIMIT_US     = 1500;
    localparam int PKT_LIMIT_CYC    = PKT_LIMIT_US * (CLK_FREQ_HZ / 1_000_000);
    localparam int MS_UNIT_MS       = 1;
    localparam int MS_UNIT_CYC      = MS_UNIT_MS * (CLK_FREQ_HZ / 1000);
    // Packet guard states
    typedef enum logic [1:0] {PRTB_IDLE, PRTB_RECV, PRTB_DROP, PRTB_RECOV} prtb_guard_t;
endpackage

// file: prtb_guard.sv
// Descrambler timeout guard: limits packet length and times lock recovery.
// Assumes synchronised receive-active and lock levels on the core clock.
`timescale 1ns/100ps
`default_nettype none
module prtb_guard
    import prtb_pkg::*;
#(
    parameter int PKT_CYC = PKT_LIMIT_CYC,
    parameter int MS_CYC  = MS_UNIT_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic       i_timer_off,
    input  wire logic [3:0] i_recov_ms,
    input  wire logic       i_rx_active,
    input  wire logic       i_lock,
    output var  logic       o_drop,
    output var  logic       o_recovering
);
    typedef struct packed {
        prtb_guard_t  st;
        logic [31:0]  cnt;
        logic [3:0]   ms;
    } prtb_gst_t;
    prtb_gst_t s;
    prtb_gst_t next_s;

    // Length check and lock recovery sequencing
    always_comb begin
        next_s = s;
        case (s.st)
            PRTB_IDLE: begin
                next_s.cnt = 32'h0000_0000;
                if (!i_lock) begin
                    next_s.st = PRTB_RECOV;
                    next_s.ms = 4'h0;
                end else if (i_rx_active) begin
                    next_s.st = PRTB_RECV;
                end
            end
            PRTB_RECV: begin
                next_s.cnt = s.cnt + 32'h0000_0001;
                if (!i_rx_active) begin
                    next_s.st = PRTB_IDLE;
                end else if (!i_timer_off && s.cnt >= 32'(PKT_CYC - 1)) begin
                    next_s.st = PRTB_DROP;  // R2
                end
            end
            PRTB_DROP: begin
                if (!i_rx_active) begin
                    next_s.st = PRTB_IDLE;
                end
            end
            PRTB_RECOV: begin
                next_s.cnt = s.cnt + 32'h0000_0001;
                if (s.cnt >= 32'(MS_CYC - 1)) begin
                    next_s.cnt = 32'h0000_0000;
                    // Saturate so a long outage cannot wrap the elapsed count
                    if (s.ms != 4'hF) begin
                        next_s.ms = s.ms + 4'h1;
                    end
                end
                if (i_lock && s.ms >= i_recov_ms) begin
                    next_s.st = PRTB_IDLE;  // R3
                end
            end
            default: next_s.st = PRTB_IDLE;
        endcase
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s <= '{st: PRTB_IDLE, cnt: 32'h0000_0000, ms: 4'h0};
        end else begin
            s <= next_s;
        end
    end

    assign o_drop       = (s.st == PRTB_DROP);
    assign o_recovering = (s.st == PRTB_RECOV);
endmodule // prtb_guard
`default_nettype wire

// file: prtb_idle.sv
// Trellis idle detector: counts consecutive idle symbols against a threshold.
// Assumes a synchronised one-cycle symbol strobe with an idle flag.
`timescale 1ns/100ps
`default_nettype none
module prtb_idle
    import prtb_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic [3:0] i_thr,
    input  wire logic       i_sym_stb,
    input  wire logic       i_sym_idle,
    output var  logic       o_idle_mode
);
    typedef struct packed {
        logic [3:0] cnt;
        logic       idle;
    } prtb_ist_t;
    prtb_ist_t s;
    prtb_ist_t next_s;

    // Count idle run, saturate, enter idle at threshold
    always_comb begin
        next_s = s;
        if (i_sym_stb) begin
            if (!i_sym_idle) begin
                next_s.cnt  = 4'h0;
                next_s.idle = 1'b0;
            end else begin
                if (s.cnt != 4'hF) begin
                    next_s.cnt = s.cnt + 4'h1;
                end
                if (s.cnt + 5'h01 >= {1'b0, i_thr}) begin
                    next_s.idle = 1'b1;  // R11
                end
            end
        end
    end

    // State register
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            s <= '{cnt: 4'h0, idle: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    assign o_idle_mode = s.idle;
endmodule // prtb_idle
`default_nettype wire

// file: prtb_bank.sv
// Receive tuning register bank with classic Wishbone slave and control outputs.
// Assumes one core clock; PHY status pins arrive asynchronously.
// Functional notes
// R1: Bypass bit routes RGMII around async FIFO
// R2: Drop packets longer than 1.5 ms
// R3: Four-bit recovery time field, ms units
// R4: Force-good-link bit reports 100M link up
// R5: Enhanced ternary detection, resets enabled
// R6: Enhanced gap detection enable bit
// R7: Skip block decoder, pass raw symbols
// R8: Scrambler off bit
// R9: Odd nibble packet detection enable
// R10: Early receive-valid enable
// R11: Idle mode when idle run reaches threshold
// R12: Software uses threshold 4 for short gaps
// R13: Reserved bits read fixed, ignore writes
//
// The Wishbone slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module prtb_bank
    import prtb_pkg::*;
#(
    parameter int PKT_CYC = PKT_LIMIT_CYC,
    parameter int MS_CYC  = MS_UNIT_CYC
) (
    input  wire logic        I_CLK,
    input  wire logic        I_RSTN,
    // Wishbone slave
    input  wire logic        I_WB_CYC,
    input  wire logic        I_WB_STB,
    input  wire logic        I_WB_WE,
    input  wire logic [9:0]  I_WB_ADR,
    input  wire logic [3:0]  I_WB_SEL,
    input  wire logic [31:0] I_WB_DAT,
    output var  logic [31:0] O_WB_DAT,
    output var  logic        O_WB_ACK,
    // PHY status pins
    input  wire logic        I_LINK_MON_OK,
    input  wire logic        I_RX_ACTIVE,
    input  wire logic        I_DESCR_LOCK,
    input  wire logic        I_SYM_STB,
    input  wire logic        I_SYM_IDLE,
    // Control outputs
    output var  logic        O_ASYNC_FIFO_SKIP_EN,
    output var  logic        O_LINK_100_GOOD,
    output var  logic        O_ENHANCED_TERNARY_DETECT_EN,
    output var  logic        O_ENHANCED_GAP_DETECT_EN,
    output var  logic        O_RX_BLOCK_DECODER_SKIP,
    output var  logic        O_SCRAMBLER_OFF,
    output var  logic        O_ODD_NIBBLE_DETECT_EN,
    output var  logic        O_EARLY_RECEIVE_VALID_EN,
    output var  logic        O_RX_PACKET_DROP,
    output var  logic        O_DESCR_RECOVERING,
    output var  logic        O_IDLE_MODE
);
    typedef struct packed {
        logic [15:0] fifo_ctrl;
        logic [15:0] fe_cfg;
        logic [15:0] idle_cfg;
        logic        ack;
        logic [31:0] rdat;
        logic [4:0]  sync1;
        logic [4:0]  sync2;
        logic [7:0]  outs;
    } prtb_bst_t;
    prtb_bst_t s;
    prtb_bst_t next_s;

    logic        req;
    logic [15:0] wr_mask;
    logic        drop;
    logic        recov;
    logic        idle_mode;

    // Byte-lane write mask for the low 16 bits
    assign wr_mask = {{8{I_WB_SEL[1]}}, {8{I_WB_SEL[0]}}};
    assign req     = I_WB_CYC && I_WB_STB && !s.ack;

    // Merge writable bits only, reserved bits keep fixed value
    function automatic logic [15:0] prtb_merge(input logic [15:0] old_v,
                                               input logic [15:0] wmask);
        prtb_merge = (old_v & ~(wmask & wr_mask)) | (I_WB_DAT[15:0] & wmask & wr_mask);
    endfunction

    // Bus access, pin synchronisers and registered control outputs
    always_comb begin
        next_s       = s;
        next_s.ack   = req;
        next_s.sync1 = {I_LINK_MON_OK, I_RX_ACTIVE, I_DESCR_LOCK, I_SYM_STB, I_SYM_IDLE};
        next_s.sync2 = s.sync1;
        if (req && I_WB_WE) begin
            case (I_WB_ADR)
                ADDR_FIFO_CTRL: next_s.fifo_ctrl = prtb_merge(s.fifo_ctrl,
                                                              WMASK_FIFO_CTRL); // R13
                ADDR_FE_CFG:    next_s.fe_cfg    = prtb_merge(s.fe_cfg, WMASK_FE_CFG); // R13
                ADDR_IDLE_CFG:  next_s.idle_cfg  = prtb_merge(s.idle_cfg,
                                                              WMASK_IDLE_CFG); // R13
                default:        next_s.fifo_ctrl = s.fifo_ctrl;
            endcase
        end
        if (req && !I_WB_WE) begin
            case (I_WB_ADR)
                ADDR_FIFO_CTRL: next_s.rdat = {16'h0000, s.fifo_ctrl};
                ADDR_FE_CFG:    next_s.rdat = {16'h0000, s.fe_cfg};
                ADDR_IDLE_CFG:  next_s.rdat = {16'h0000, s.idle_cfg};
                default:        next_s.rdat = 32'h0000_0000;
            endcase
        end
        next_s.outs[0] = s.fifo_ctrl[POS_FIFO_SKIP];  // R1
        next_s.outs[1] = s.fe_cfg[POS_FORCE_LINK] | s.sync2[4];  // R4
        next_s.outs[2] = s.fe_cfg[POS_TERNARY];  // R5
        next_s.outs[3] = s.fe_cfg[POS_GAP];  // R6
        next_s.outs[4] = s.fe_cfg[POS_DEC_SKIP];  // R7
        next_s.outs[5] = s.fe_cfg[POS_SCR_OFF];  // R8
        next_s.outs[6] = s.fe_cfg[POS_ODD_NIB];  // R9
        next_s.outs[7] = s.fe_cfg[POS_EARLY_DV];  // R10
    end

    // State register
    always_ff @(posedge I_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            // Lock synchroniser stages start high so reset is not seen as lock loss
            s <= '{fifo_ctrl: RST_FIFO_CTRL, fe_cfg: RST_FE_CFG, idle_cfg: RST_IDLE_CFG,
                   ack: 1'b0, rdat: 32'h0000_0000, sync1: 5'h04, sync2: 5'h04,
                   outs: 8'h04};
        end else begin
            s <= next_s;
        end
    end

    // Packet length guard and lock recovery timer
    prtb_guard #(
        .PKT_CYC (PKT_CYC),
        .MS_CYC  (MS_CYC)
    ) u_guard (
        .i_clk        (I_CLK),
        .i_rstn       (I_RSTN),
        .i_timer_off  (s.fe_cfg[POS_TMR_OFF]),  // R2
        .i_recov_ms   (s.fe_cfg[POS_RECOV_LO +: 4]),  // R3
        .i_rx_active  (s.sync2[3]),
        .i_lock       (s.sync2[2]),
        .o_drop       (drop),
        .o_recovering (recov)
    );

    // Idle symbol run detector
    prtb_idle u_idle (
        .i_clk       (I_CLK),
        .i_rstn      (I_RSTN),
        .i_thr       (s.idle_cfg[3:0]),  // R11
        .i_sym_stb   (s.sync2[1]),
        .i_sym_idle  (s.sync2[0]),
        .o_idle_mode (idle_mode)
    );

    assign O_WB_ACK                     = s.ack;
    assign O_WB_DAT                     = s.rdat;
    assign O_ASYNC_FIFO_SKIP_EN         = s.outs[0];
    assign O_LINK_100_GOOD              = s.outs[1];
    assign O_ENHANCED_TERNARY_DETECT_EN = s.outs[2];
    assign O_ENHANCED_GAP_DETECT_EN     = s.outs[3];
    assign O_RX_BLOCK_DECODER_SKIP      = s.outs[4];
    assign O_SCRAMBLER_OFF              = s.outs[5];
    assign O_ODD_NIBBLE_DETECT_EN       = s.outs[6];
    assign O_EARLY_RECEIVE_VALID_EN     = s.outs[7];
    assign O_RX_PACKET_DROP             = drop;
    assign O_DESCR_RECOVERING           = recov;
    assign O_IDLE_MODE                  = idle_mode;
endmodule // prtb_bank
`default_nettype wire

// file: prtb_bank_sva.sv
// Checker for the receive tuning bank: bus handshake, readback and control outputs.
// Assumes only the top module ports; bound to every bank instance at the foot.
`timescale 1ns/100ps
`default_nettype none
module prtb_bank_chk
    import prtb_pkg::*;
#(
    parameter int PKT_CYC = PKT_LIMIT_CYC,
    parameter int MS_CYC  = MS_UNIT_CYC
) (
    input wire logic        I_CLK,
    input wire logic        I_RSTN,
    input wire logic        I_WB_CYC,
    input wire logic        I_WB_STB,
    input wire logic        I_WB_WE,
    input wire logic [9:0]  I_WB_ADR,
    input wire logic [3:0]  I_WB_SEL,
    input wire logic [31:0] I_WB_DAT,
    input wire logic [31:0] O_WB_DAT,
    input wire logic        O_WB_ACK,
    input wire logic        O_ASYNC_FIFO_SKIP_EN,
    input wire logic        O_LINK_100_GOOD,
    input wire logic        O_ENHANCED_TERNARY_DETECT_EN,
    input wire logic        O_SCRAMBLER_OFF
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (!I_RSTN);
    // Request taken, then write or read to one place
    sequence s_req;
        I_WB_CYC && I_WB_STB && !O_WB_ACK;
    endsequence
    sequence s_wr(logic [9:0] a);
        s_req ##0 (I_WB_WE && I_WB_SEL[0] && I_WB_ADR == a);
    endsequence
    sequence s_rd(logic [9:0] a);
        s_req ##0 (!I_WB_WE && I_WB_ADR == a);
    endsequence
    property p_ack;
        s_req |=> O_WB_ACK ##1 !O_WB_ACK;
    endproperty
    a_ack: assert property (p_ack) else $error("ack late or too long");
    property p_fifo;
        s_wr(ADDR_FIFO_CTRL) |-> ##2 O_ASYNC_FIFO_SKIP_EN == $past(I_WB_DAT[4], 2);
    endproperty
    a_fifo: assert property (p_fifo) else $error("fifo skip not following write");
    property p_force;
        s_wr(ADDR_FE_CFG) ##0 I_WB_DAT[6] |-> ##2 O_LINK_100_GOOD;
    endproperty
    a_force: assert property (p_force) else $error("forced link not reported");
    property p_tern;
        s_wr(ADDR_FE_CFG) |-> ##2 O_ENHANCED_TERNARY_DETECT_EN == $past(I_WB_DAT[5], 2);
    endproperty
    a_tern: assert property (p_tern) else $error("ternary detect not following");
    property p_scr;
        s_wr(ADDR_FE_CFG) |-> ##2 O_SCRAMBLER_OFF == $past(I_WB_DAT[2], 2);
    endproperty
    a_scr: assert property (p_scr) else $error("scrambler off not following");
    property p_rd_fifo;
        s_rd(ADDR_FIFO_CTRL) |=> O_WB_DAT == {27'h000_0000, O_ASYNC_FIFO_SKIP_EN, 4'h0};
    endproperty
    a_rd_fifo: assert property (p_rd_fifo) else $error("fifo register readback");
    property p_rd_idle;
        s_rd(ADDR_IDLE_CFG) |=> O_WB_DAT[31:4] == 28'h000_0205;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("idle register fixed bits");
    property p_unmap;
        s_req ##0 (!I_WB_WE && I_WB_ADR != ADDR_FIFO_CTRL && I_WB_ADR != ADDR_FE_CFG
            && I_WB_ADR != ADDR_IDLE_CFG) |=> O_WB_DAT == 32'h0000_0000;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule // prtb_bank_chk

bind prtb_bank prtb_bank_chk #(.PKT_CYC(PKT_CYC), .MS_CYC(MS_CYC)) chk_u (
    .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
    .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR), .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT),
    .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK), .O_ASYNC_FIFO_SKIP_EN(O_ASYNC_FIFO_SKIP_EN),
    .O_LINK_100_GOOD(O_LINK_100_GOOD), .O_SCRAMBLER_OFF(O_SCRAMBLER_OFF),
    .O_ENHANCED_TERNARY_DETECT_EN(O_ENHANCED_TERNARY_DETECT_EN)
);
`default_nettype wire

// file: tb.sv
// Self-checking bench for the receive tuning bank over classic Wishbone.
// Assumes short packet and millisecond counts through the bank parameters.
`timescale 1ns/100ps
`default_nettype none
module tb
    import prtb_pkg::*;
;
    localparam int PKT = 50;
    localparam int MSC = 10;
    // Rows: address, write data, expected readback
    localparam logic [41:0] ROWS [8] = '{
        {ADDR_FIFO_CTRL, 16'hFFFF, 16'h0010}, {ADDR_FE_CFG, 16'hFFFF, 16'h0FFF},
        {ADDR_IDLE_CFG, 16'hFFFF, 16'h205F}, {10'h3FC, 16'hFFFF, 16'h0000},
        {ADDR_FIFO_CTRL, 16'h0000, 16'h0000}, {ADDR_FE_CFG, 16'h0555, 16'h0555},
        {ADDR_FE_CFG, 16'h02AA, 16'h02AA}, {ADDR_IDLE_CFG, 16'h0004, 16'h2054}
    };
    logic        clk, rstn, cyc, stb, we, link, rxa, lock, sstb, sidl, ack, drop, recov, idle;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat, rdat, q;
    wire  [7:0]  ctl;
    logic [15:0] fe_m, fifo_m;
    int          err_total, checks;

    prtb_bank #(.PKT_CYC(PKT), .MS_CYC(MSC)) dut_u (
        .I_CLK(clk), .I_RSTN(rstn), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we),
        .I_WB_ADR(adr), .I_WB_SEL(sel), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
        .I_LINK_MON_OK(link), .I_RX_ACTIVE(rxa), .I_DESCR_LOCK(lock), .I_SYM_STB(sstb),
        .I_SYM_IDLE(sidl), .O_ASYNC_FIFO_SKIP_EN(ctl[7]), .O_LINK_100_GOOD(ctl[6]),
        .O_ENHANCED_TERNARY_DETECT_EN(ctl[5]), .O_ENHANCED_GAP_DETECT_EN(ctl[4]),
        .O_RX_BLOCK_DECODER_SKIP(ctl[3]), .O_SCRAMBLER_OFF(ctl[2]),
        .O_ODD_NIBBLE_DETECT_EN(ctl[1]), .O_EARLY_RECEIVE_VALID_EN(ctl[0]),
        .O_RX_PACKET_DROP(drop), .O_DESCR_RECOVERING(recov), .O_IDLE_MODE(idle)
    );

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One classic bus cycle; read data lands in q
    task automatic wb(input logic w, input logic [9:0] a, input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk({31'h0000_0000, ack}, 32'h0000_0001);
    endtask

    task automatic finish_test;
        $display("Totals: %0d mismatches, %0d checks", err_total, checks);
        if (err_total == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        finish_test();
    end

    initial begin
        {cyc, stb, we, link, rxa, sstb, sidl, rstn} = '0;
        lock = 1'b1;
        adr = '0;
        sel = 4'h3;
        wdat = '0;
        err_total = 0;
        checks = 0;
        fifo_m = 16'h0000;
        fe_m = 16'h07A0;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        // Table: write, read back, then compare the control outputs
        foreach (ROWS[i]) begin
            wb(1'b1, ROWS[i][41:32], ROWS[i][31:16]);
            wb(1'b0, ROWS[i][41:32], 16'h0000);
            chk(q, {16'h0000, ROWS[i][15:0]});
            if (ROWS[i][41:32] == ADDR_FIFO_CTRL) fifo_m = ROWS[i][15:0];
            if (ROWS[i][41:32] == ADDR_FE_CFG) fe_m = ROWS[i][15:0];
            chk({24'h00_0000, ctl}, {24'h00_0000, fifo_m[4], fe_m[6] | link, fe_m[5:0]});
        end
        // Reset in mid-run restores the defaults
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        wb(1'b0, ADDR_FIFO_CTRL, 16'h0000);
        chk(q, 32'h0000_0000);
        wb(1'b0, ADDR_FE_CFG, 16'h0000);
        chk(q, 32'h0000_07A0);
        wb(1'b0, ADDR_IDLE_CFG, 16'h0000);
        chk(q, 32'h0000_2055);
        chk({24'h00_0000, ctl}, 32'h0000_0020);
        chk({31'h0000_0000, recov}, 32'h0000_0000);
        // Overlong packet dropped while enforcement is on, kept when off
        rxa <= 1'b1;
        repeat (PKT - 20) @(posedge clk);
        chk({31'h0000_0000, drop}, 32'h0000_0000);
        repeat (40) @(posedge clk);
        chk({31'h0000_0000, drop}, 32'h0000_0001);
        rxa <= 1'b0;
        wb(1'b1, ADDR_FE_CFG, 16'h0FA0);
        rxa <= 1'b1;
        repeat (PKT + 30) @(posedge clk);
        chk({31'h0000_0000, drop}, 32'h0000_0000);
        rxa <= 1'b0;
        // Lock loss with two units of recovery
        wb(1'b1, ADDR_FE_CFG, 16'h0120);
        lock <= 1'b0;
        repeat (5) @(posedge clk);
        lock <= 1'b1;
        repeat (5) @(posedge clk);
        chk({31'h0000_0000, recov}, 32'h0000_0001);
        repeat (25) @(posedge clk);
        chk({31'h0000_0000, recov}, 32'h0000_0000);
        // Idle run against a threshold of four
        wb(1'b1, ADDR_IDLE_CFG, 16'h0004);
        sidl <= 1'b1;
        for (int k = 1; k <= 4; k++) begin
            sstb <= 1'b1;
            @(posedge clk);
            sstb <= 1'b0;
            repeat (5) @(posedge clk);
            chk({31'h0000_0000, idle}, {31'h0000_0000, k == 4});
        end
        // Monitor link good passes through without the force bit
        link <= 1'b1;
        repeat (5) @(posedge clk);
        chk({31'h0000_0000, ctl[6]}, 32'h0000_0001);
        finish_test();
    end
endmodule // tb
`default_nettype wire
